// ===== hw/cc_map.svh
// Constants of the contactless card command block: codes, layouts, timing
// Functional notes
// RL1: Strong and normal modulation; strong at delivery
// RL2: New modulation applies after unselect or field reset
// RL3: Modulation setting stays rewritable, never locked
// RL4: Config only after sector 0 first-key authentication
// RL5: Config frame 43h, type, CRC; 4-bit reply
// RL6: Type 01h strong, 00h normal
// RL7: Block 0 status byte 20h strong, 00h normal
// RL8: Authentication is two command/response pairs
// RL9: Part one: 60h/61h, block address, CRC
// RL10: Card answers part one with 4-byte challenge
// RL11: Part two: 8-byte reader token, 4-byte reply
// RL12: Reader waits frame delay between auth parts
// RL13: Authentication uses last-cascade 4 identifier bytes
// RL14: Read 30h, address, CRC; 16 bytes or NAK
// RL15: Block address is one full byte
// RL16: Plain block 0 read only after shortcut
// RL17: Reader timeouts 1 ms auth, 5 ms others
// RL18: Bad auth or CRC on config gives NAK
`ifndef CC_MAP_SVH
`define CC_MAP_SVH

`define CC_CMD_MODCFG   8'h43
`define CC_CMD_AUTH_A   8'h60
`define CC_CMD_AUTH_B   8'h61
`define CC_CMD_READ     8'h30
`define CC_MOD_STRONG   8'h01
`define CC_MOD_NORMAL   8'h00
`define CC_STAT_STRONG  8'h20
`define CC_STAT_NORMAL  8'h00
`define CC_MOD_RST      1'b1
`define CC_MOD_BYTE_IDX 8
`define CC_SEC0_LAST    8'h03
`define CC_ACK          4'ha
`define CC_NAK          4'h0
`define CC_CRC_INIT     16'h6363
`define CC_FRM_LEN      4'h4
`define CC_TOK_LEN      4'h8
`define CC_CHAL_LEN     5'h04
`define CC_BLK_LEN      5'h12
`define CC_FDT_CYC      4'h9
`define CC_GAP_CYC      8'h12
`define CC_CLK_MHZ      10
`define CC_TO_AUTH_US   1000
`define CC_TO_CMD_US    5000
`define CC_TO_AUTH_CYC  (`CC_TO_AUTH_US * `CC_CLK_MHZ)
`define CC_TO_CMD_CYC   (`CC_TO_CMD_US * `CC_CLK_MHZ)

`endif

// ===== hw/cc_pkg.sv
// Types and the frame check function shared by both link ends
package cc_pkg;

  typedef enum logic [2:0] {C_IDLE, C_CHAL, C_TOK, C_MEM, C_WAIT, C_TX}
    cc_cst_t;
  typedef enum logic [1:0] {R_IDLE, R_TX, R_RX, R_GAP} cc_rst_t;

  typedef struct packed {
    cc_cst_t      st;
    logic [63:0]  rx_buf;
    logic [3:0]   rx_cnt;
    logic [143:0] tx_buf;
    logic [4:0]   tx_cnt;
    logic         tx_nib;
    logic [3:0]   nib;
    logic [3:0]   dly;
    logic         ph2;
    logic         authed;
    logic         key_b;
    logic [7:0]   blk;
    logic [31:0]  uid;
    logic         mod_cfg;
    logic         mod_act;
    logic         sel_d;
    logic [7:0]   mem_addr;
    logic         chal_req;
    logic         tok_req;
    logic [63:0]  rdr_tok;
    logic         c2r_vld;
    logic [7:0]   c2r_dat;
    logic         c2r_end;
    logic         c2r_nib;
  } cc_card_st_t;

  typedef struct packed {
    cc_rst_t      st;
    logic         lclk;
    logic         field;
    logic         sel;
    logic         r2c_vld;
    logic [7:0]   r2c_dat;
    logic         r2c_end;
    logic [79:0]  tbuf;
    logic [3:0]   tcnt;
    logic [15:0]  to_cnt;
    logic [7:0]   gap;
    logic [143:0] rbuf;
    logic [4:0]   rcnt;
    logic         rdy;
    logic         rsp_vld;
    logic         rsp_nib;
    logic [4:0]   rsp_len;
    logic [143:0] rsp_data;
    logic         timeout;
  } cc_rdr_st_t;

  // One byte of the 16-bit frame check, low bit first
  function automatic logic [15:0] cc_crc_upd(input logic [15:0] crc,
                                             input logic [7:0]  d);
    logic [7:0] b;
    b = d ^ crc[7:0];
    b = b ^ {b[3:0], 4'h0};
    cc_crc_upd = {8'h00, crc[15:8]} ^ {b, 8'h00} ^ {5'h00, b, 3'h0}
               ^ {12'h000, b[7:4]};
  endfunction

endpackage

// ===== hw/cc_link_if.sv
// Byte-level contactless link between reader and card
`timescale 1ns/1ps
interface cc_link_if;
  logic       clk;
  logic       field_on;
  logic       sel;
  logic       r2c_vld;
  logic [7:0] r2c_dat;
  logic       r2c_end;
  logic       c2r_vld;
  logic [7:0] c2r_dat;
  logic       c2r_end;
  logic       c2r_nib;

  modport reader (output clk, field_on, sel, r2c_vld, r2c_dat, r2c_end,
                  input  c2r_vld, c2r_dat, c2r_end, c2r_nib);
  modport card   (input  clk, field_on, sel, r2c_vld, r2c_dat, r2c_end,
                  output c2r_vld, c2r_dat, c2r_end, c2r_nib);
endinterface

// ===== hw/cc_card.sv
// Card end: modulation config, three-pass authentication and block read
`timescale 1ns/1ps
`include "cc_map.svh"
module cc_card (
  cc_link_if.card            lnk,
  input  wire logic          i_rst_n,
  input  wire logic [31:0]   i_uid4,
  input  wire logic          i_shortcut,
  output logic [7:0]         o_mem_addr,
  input  wire logic [127:0]  i_mem_data,
  output logic               o_chal_req,
  output logic               o_key_b,
  output logic [7:0]         o_auth_blk,
  output logic [31:0]        o_auth_uid,
  input  wire logic          i_chal_vld,
  input  wire logic [31:0]   i_chal,
  output logic               o_tok_req,
  output logic [63:0]        o_rdr_tok,
  input  wire logic          i_tok_done,
  input  wire logic          i_tok_ok,
  input  wire logic [31:0]   i_card_tok,
  output logic               o_authed,
  output logic               o_mod_strong,
  output logic               o_mod_cfg
);
  import cc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  cc_card_st_t  s_ff;
  cc_card_st_t  nxt_s;
  logic [63:0]  nb;
  logic [3:0]   ncnt;
  logic [15:0]  calc;
  logic [127:0] blk_d;
  logic [15:0]  crc_d;
  logic         go_nib;
  logic [3:0]   nib_v;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_s  = s_ff;
    nb     = {s_ff.rx_buf[55:0], lnk.r2c_dat};
    ncnt   = (s_ff.rx_cnt == 4'hf) ? s_ff.rx_cnt : s_ff.rx_cnt + 4'h1;
    calc   = cc_crc_upd(cc_crc_upd(`CC_CRC_INIT, nb[31:24]), nb[23:16]);
    blk_d  = i_mem_data;
    crc_d  = `CC_CRC_INIT;
    go_nib = 1'b0;
    nib_v  = `CC_NAK;
    nxt_s.chal_req = 1'b0;
    nxt_s.tok_req  = 1'b0;
    nxt_s.c2r_vld  = 1'b0;
    nxt_s.c2r_end  = 1'b0;
    nxt_s.c2r_nib  = 1'b0;
    nxt_s.sel_d    = lnk.sel;
    // Status byte shows the stored setting, not the one in force
    if (s_ff.mem_addr == 8'h00) begin
      blk_d[127-8*`CC_MOD_BYTE_IDX -: 8] =
        s_ff.mod_cfg ? `CC_STAT_STRONG : `CC_STAT_NORMAL; // [RL7]
    end
    for (int i = 0; i < 16; i++) begin
      crc_d = cc_crc_upd(crc_d, blk_d[127-8*i -: 8]);
    end
    unique case (s_ff.st)
      C_IDLE: begin
        if (lnk.r2c_vld) begin
          nxt_s.rx_buf = nb;
          nxt_s.rx_cnt = ncnt;
          if (lnk.r2c_end) begin
            nxt_s.rx_cnt = 4'h0;
            nxt_s.ph2    = 1'b0;
            if (s_ff.ph2 && ncnt == `CC_TOK_LEN) begin
              nxt_s.rdr_tok = nb; // [RL11]
              nxt_s.tok_req = 1'b1;
              nxt_s.st      = C_TOK;
            end else if (ncnt != `CC_FRM_LEN ||
                         calc != {nb[7:0], nb[15:8]}) begin
              go_nib = 1'b1; // [RL18]
            end else begin
              case (nb[31:24])
                `CC_CMD_MODCFG: begin // [RL5]
                  if (s_ff.authed && !s_ff.key_b &&
                      s_ff.blk <= `CC_SEC0_LAST &&
                      nb[23:17] == 7'h00) begin // [RL4]
                    // Every accepted write lands again [RL3]
                    nxt_s.mod_cfg = (nb[23:16] == `CC_MOD_STRONG); // [RL6]
                    nib_v  = `CC_ACK;
                  end
                  go_nib = 1'b1; // [RL18]
                end
                `CC_CMD_AUTH_A,
                `CC_CMD_AUTH_B: begin // [RL8] [RL9]
                  nxt_s.authed   = 1'b0;
                  nxt_s.key_b    = nb[24];
                  nxt_s.blk      = nb[23:16]; // [RL15]
                  nxt_s.uid      = i_uid4; // [RL13]
                  nxt_s.chal_req = 1'b1;
                  nxt_s.st       = C_CHAL;
                end
                `CC_CMD_READ: begin // [RL14]
                  if (s_ff.authed ||
                      (nb[23:16] == 8'h00 && i_shortcut)) begin // [RL16]
                    nxt_s.mem_addr = nb[23:16]; // [RL15]
                    nxt_s.st       = C_MEM;
                  end else begin
                    go_nib = 1'b1;
                  end
                end
                default: go_nib = 1'b1;
              endcase
            end
          end
        end
      end
      C_CHAL: begin
        if (i_chal_vld) begin
          nxt_s.tx_buf = {i_chal, 112'h0}; // [RL10]
          nxt_s.tx_cnt = `CC_CHAL_LEN;
          nxt_s.tx_nib = 1'b0;
          nxt_s.ph2    = 1'b1;
          nxt_s.dly    = `CC_FDT_CYC;
          nxt_s.st     = C_WAIT;
        end
      end
      C_TOK: begin
        if (i_tok_done) begin
          nxt_s.authed = i_tok_ok;
          if (i_tok_ok) begin
            nxt_s.tx_buf = {i_card_tok, 112'h0}; // [RL11]
            nxt_s.tx_cnt = `CC_CHAL_LEN;
            nxt_s.tx_nib = 1'b0;
            nxt_s.dly    = `CC_FDT_CYC;
            nxt_s.st     = C_WAIT;
          end else begin
            go_nib = 1'b1;
          end
        end
      end
      C_MEM: begin
        nxt_s.tx_buf = {blk_d, crc_d[7:0], crc_d[15:8]}; // [RL14]
        nxt_s.tx_cnt = `CC_BLK_LEN;
        nxt_s.tx_nib = 1'b0;
        nxt_s.dly    = `CC_FDT_CYC;
        nxt_s.st     = C_WAIT;
      end
      C_WAIT: begin
        // Least reply delay so the reader can turn its receiver round
        nxt_s.dly = s_ff.dly - 4'h1;
        if (s_ff.dly == 4'h1) begin
          nxt_s.st = C_TX;
        end
      end
      C_TX: begin
        nxt_s.c2r_vld = 1'b1;
        if (s_ff.tx_nib) begin
          nxt_s.c2r_nib = 1'b1;
          nxt_s.c2r_end = 1'b1;
          nxt_s.c2r_dat = {4'h0, s_ff.nib}; // [RL5]
          nxt_s.tx_nib  = 1'b0;
          nxt_s.st      = C_IDLE;
        end else begin
          nxt_s.c2r_dat = s_ff.tx_buf[143:136];
          nxt_s.tx_buf  = {s_ff.tx_buf[135:0], 8'h00};
          nxt_s.tx_cnt  = s_ff.tx_cnt - 5'h01;
          nxt_s.c2r_end = (s_ff.tx_cnt == 5'h01);
          if (s_ff.tx_cnt == 5'h01) begin
            nxt_s.st = C_IDLE;
          end
        end
      end
    endcase
    if (go_nib) begin
      nxt_s.tx_nib = 1'b1;
      nxt_s.nib    = nib_v;
      nxt_s.dly    = `CC_FDT_CYC;
      nxt_s.st     = C_WAIT;
    end
    // Field loss or unselect ends the session and loads the setting
    if (!lnk.field_on || (s_ff.sel_d && !lnk.sel)) begin
      nxt_s.st      = C_IDLE;
      nxt_s.authed  = 1'b0;
      nxt_s.ph2     = 1'b0;
      nxt_s.rx_cnt  = 4'h0;
      nxt_s.tx_nib  = 1'b0;
      nxt_s.c2r_vld = 1'b0;
      nxt_s.c2r_end = 1'b0;
      nxt_s.c2r_nib = 1'b0;
      nxt_s.mod_act = nxt_s.mod_cfg; // [RL2]
    end
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge lnk.clk) begin
    if (!i_rst_n) begin
      s_ff         <= '0;
      s_ff.mod_cfg <= `CC_MOD_RST; // [RL1]
      s_ff.mod_act <= `CC_MOD_RST; // [RL1]
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lnk.c2r_vld  = s_ff.c2r_vld;
  assign lnk.c2r_dat  = s_ff.c2r_dat;
  assign lnk.c2r_end  = s_ff.c2r_end;
  assign lnk.c2r_nib  = s_ff.c2r_nib;
  assign o_mem_addr   = s_ff.mem_addr;
  assign o_chal_req   = s_ff.chal_req;
  assign o_key_b      = s_ff.key_b;
  assign o_auth_blk   = s_ff.blk;
  assign o_auth_uid   = s_ff.uid;
  assign o_tok_req    = s_ff.tok_req;
  assign o_rdr_tok    = s_ff.rdr_tok;
  assign o_authed     = s_ff.authed;
  assign o_mod_strong = s_ff.mod_act; // [RL1]
  assign o_mod_cfg    = s_ff.mod_cfg;

endmodule

// ===== hw/cc_reader.sv
// Reader end: link clock divider, frame sender, reply collector, timeouts
`timescale 1ns/1ps
`include "cc_map.svh"
module cc_reader #(
  parameter int P_TO_AUTH_CYC = `CC_TO_AUTH_CYC,
  parameter int P_TO_CMD_CYC  = `CC_TO_CMD_CYC
) (
  cc_link_if.reader          lnk,
  input  wire logic          i_clk,
  input  wire logic          i_rst_n,
  input  wire logic          i_field_on,
  input  wire logic          i_sel,
  input  wire logic          i_req_vld,
  input  wire logic [3:0]    i_req_len,
  input  wire logic [63:0]   i_req_data,
  input  wire logic          i_req_crc,
  output logic               o_req_rdy,
  output logic               o_rsp_vld,
  output logic               o_rsp_nib,
  output logic [4:0]         o_rsp_len,
  output logic [143:0]       o_rsp_data,
  output logic               o_timeout
);
  import cc_pkg::*;

  // ****************************************************************
  // State
  // ****************************************************************
  cc_rdr_st_t  s_ff;
  cc_rdr_st_t  nxt_s;
  logic [15:0] crc_t;
  logic [79:0] tb;
  logic        is_auth;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    nxt_s   = s_ff;
    crc_t   = `CC_CRC_INIT;
    tb      = {i_req_data, 16'h0000};
    is_auth = (i_req_data[63:56] == `CC_CMD_AUTH_A) ||
              (i_req_data[63:56] == `CC_CMD_AUTH_B) || !i_req_crc;
    for (int i = 0; i < 8; i++) begin
      if (i < int'(i_req_len)) begin
        crc_t = cc_crc_upd(crc_t, i_req_data[63-8*i -: 8]);
      end
    end
    if (i_req_crc) begin
      tb[79-8*int'(i_req_len) -: 16] = {crc_t[7:0], crc_t[15:8]};
    end
    nxt_s.lclk    = ~s_ff.lclk;
    nxt_s.rsp_vld = 1'b0;
    nxt_s.timeout = 1'b0;
    // Link pins move only on the falling link edge
    if (s_ff.lclk) begin
      nxt_s.field   = i_field_on;
      nxt_s.sel     = i_sel;
      nxt_s.r2c_vld = 1'b0;
      nxt_s.r2c_end = 1'b0;
    end
    unique case (s_ff.st)
      R_IDLE: begin
        nxt_s.rdy = 1'b1;
        if (i_req_vld && s_ff.rdy && i_req_len != 4'h0) begin
          nxt_s.rdy    = 1'b0;
          nxt_s.tbuf   = tb;
          nxt_s.tcnt   = i_req_crc ? i_req_len + 4'h2 : i_req_len;
          nxt_s.to_cnt = is_auth ? 16'(P_TO_AUTH_CYC)
                                 : 16'(P_TO_CMD_CYC); // [RL17]
          nxt_s.st     = R_TX;
        end
      end
      R_TX: begin
        if (s_ff.lclk) begin
          nxt_s.r2c_vld = 1'b1;
          nxt_s.r2c_dat = s_ff.tbuf[79:72];
          nxt_s.r2c_end = (s_ff.tcnt == 4'h1);
          nxt_s.tbuf    = {s_ff.tbuf[71:0], 8'h00};
          nxt_s.tcnt    = s_ff.tcnt - 4'h1;
          if (s_ff.tcnt == 4'h1) begin
            nxt_s.rcnt = 5'h00;
            nxt_s.st   = R_RX;
          end
        end
      end
      R_RX: begin
        nxt_s.to_cnt = s_ff.to_cnt - 16'h0001;
        if (!s_ff.lclk && lnk.c2r_vld) begin
          nxt_s.rbuf = {s_ff.rbuf[135:0], lnk.c2r_dat};
          nxt_s.rcnt = s_ff.rcnt + 5'h01;
          if (lnk.c2r_end || lnk.c2r_nib) begin
            nxt_s.rsp_vld  = 1'b1;
            nxt_s.rsp_nib  = lnk.c2r_nib;
            nxt_s.rsp_len  = s_ff.rcnt + 5'h01;
            nxt_s.rsp_data = {s_ff.rbuf[135:0], lnk.c2r_dat};
            nxt_s.gap      = `CC_GAP_CYC;
            nxt_s.st       = R_GAP;
          end
        end else if (s_ff.to_cnt == 16'h0001) begin
          nxt_s.timeout = 1'b1; // [RL17]
          nxt_s.gap     = `CC_GAP_CYC;
          nxt_s.st      = R_GAP;
        end
      end
      R_GAP: begin
        // Holds off the next frame, e.g. the second auth part
        nxt_s.gap = s_ff.gap - 8'h01; // [RL12]
        if (s_ff.gap == 8'h01) begin
          nxt_s.st = R_IDLE;
        end
      end
    endcase
  end

  // ****************************************************************
  // Registers
  // ****************************************************************
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      s_ff <= '0;
    end else begin
      s_ff <= nxt_s;
    end
  end

  assign lnk.clk      = s_ff.lclk;
  assign lnk.field_on = s_ff.field;
  assign lnk.sel      = s_ff.sel;
  assign lnk.r2c_vld  = s_ff.r2c_vld;
  assign lnk.r2c_dat  = s_ff.r2c_dat;
  assign lnk.r2c_end  = s_ff.r2c_end;
  assign o_req_rdy    = s_ff.rdy;
  assign o_rsp_vld    = s_ff.rsp_vld;
  assign o_rsp_nib    = s_ff.rsp_nib;
  assign o_rsp_len    = s_ff.rsp_len;
  assign o_rsp_data   = s_ff.rsp_data;
  assign o_timeout    = s_ff.timeout;

endmodule

// ===== bench/cc_link_monitor.sv
// Link checker: reply shapes, frame delay and byte pacing on the link
`timescale 1ns/1ps
module cc_link_monitor (
  input  wire logic       clk,
  input  wire logic       i_rst_n,
  input  wire logic       field_on,
  input  wire logic       sel,
  input  wire logic       r2c_vld,
  input  wire logic [7:0] r2c_dat,
  input  wire logic       r2c_end,
  input  wire logic       c2r_vld,
  input  wire logic [7:0] c2r_dat,
  input  wire logic       c2r_end,
  input  wire logic       c2r_nib
);
  logic [3:0] rcnt_ff;
  logic [3:0] rlen_ff;
  logic [7:0] rcmd_ff;
  logic [4:0] ccnt_ff;
  logic       rend;
  logic       cend;
  logic       auth;

  assign rend = r2c_vld && r2c_end;
  assign cend = c2r_vld && c2r_end && !c2r_nib;
  assign auth = rcmd_ff == 8'h60 || rcmd_ff == 8'h61;

  // Length and first byte of the last reader frame, bytes of card reply
  always_ff @(posedge clk) begin
    if (!i_rst_n) begin
      rcnt_ff <= 4'h0;
      rlen_ff <= 4'h0;
      rcmd_ff <= 8'h00;
      ccnt_ff <= 5'h00;
    end else begin
      rcnt_ff <= r2c_vld ? (r2c_end ? 4'h0 : rcnt_ff + 4'h1) : rcnt_ff;
      rlen_ff <= rend ? rcnt_ff + 4'h1 : rlen_ff;
      rcmd_ff <= (r2c_vld && rcnt_ff == 4'h0) ? r2c_dat : rcmd_ff;
      ccnt_ff <= c2r_vld ? (c2r_end ? 5'h00 : ccnt_ff + 5'h01) : ccnt_ff;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!i_rst_n);

  nib_reply_a: assert property (
    c2r_vld && c2r_nib |-> c2r_end && ccnt_ff == 5'h00
      && c2r_dat[3:0] inside {4'ha, 4'h0}) else $error("bad nibble reply");
  frame_delay_a: assert property (
    rend |=> !c2r_vld [*8] ##1 !c2r_vld) else $error("reply too early");
  reply_due_a: assert property (
    rend && sel && field_on |-> ##[10:80] c2r_vld) else $error("no reply");
  modcfg_nib_a: assert property (
    c2r_vld && c2r_end && rlen_ff == 4'h4 && rcmd_ff == 8'h43 |-> c2r_nib)
    else $error("config reply not a nibble");
  chal_len_a: assert property (
    cend && rlen_ff == 4'h4 && auth |-> ccnt_ff == 5'h03)
    else $error("challenge length");
  token_len_a: assert property (
    cend && rlen_ff == 4'h8 |-> ccnt_ff == 5'h03) else $error("token length");
  read_len_a: assert property (
    cend && rlen_ff == 4'h4 && rcmd_ff == 8'h30 |-> ccnt_ff == 5'h11)
    else $error("read reply length");
  card_pace_a: assert property (
    c2r_vld && !c2r_end |=> c2r_vld) else $error("card byte gap");
  rdr_pace_a: assert property (
    r2c_vld && !r2c_end |=> r2c_vld) else $error("reader byte gap");
  rdr_gap_a: assert property (
    c2r_vld && c2r_end |=> !r2c_vld [*8]) else $error("reader gap short");
endmodule

// ===== bench/contactless_card_auth_read_modcfg_tb.sv
// Testbench joining reader and card ends across the link interface
`timescale 1ns/1ps
module contactless_card_auth_read_modcfg_tb;
  import cc_pkg::*;
  typedef struct packed {
    logic         to;
    logic         nib;
    logic [4:0]   len;
    logic [127:0] dat;
  } cc_exp_t;

  logic i_clk, rst_n, card_rst_n, field_on, sel, req_vld, req_crc, rdy;
  logic rsp_vld, rsp_nib, tmo, shortcut, chal_req, key_b, chal_vld;
  logic tok_req, tok_done, tok_ok, authed, mod_strong, mod_cfg, exp_key;
  logic cfg_exp;
  logic [3:0]   req_len;
  logic [4:0]   rsp_len;
  logic [7:0]   mem_addr, auth_blk, exp_blk;
  logic [31:0]  uid, auth_uid, chal, card_tok, rs, a;
  logic [63:0]  req_data, rdr_tok, exp_tok;
  logic [127:0] mem_data, go;
  logic [143:0] rsp_data;
  cc_exp_t      eo;
  cc_exp_t      exp_q[$];
  int           errors, n_compared, cyc;

  cc_link_if lnk ();
  cc_reader #(.P_TO_AUTH_CYC(200), .P_TO_CMD_CYC(400)) u_cc_reader (
    .lnk(lnk), .i_clk(i_clk), .i_rst_n(rst_n), .i_field_on(field_on),
    .i_sel(sel), .i_req_vld(req_vld), .i_req_len(req_len),
    .i_req_data(req_data), .i_req_crc(req_crc), .o_req_rdy(rdy),
    .o_rsp_vld(rsp_vld), .o_rsp_nib(rsp_nib), .o_rsp_len(rsp_len),
    .o_rsp_data(rsp_data), .o_timeout(tmo));
  cc_card u_cc_card (
    .lnk(lnk), .i_rst_n(card_rst_n), .i_uid4(uid), .i_shortcut(shortcut),
    .o_mem_addr(mem_addr), .i_mem_data(mem_data), .o_chal_req(chal_req),
    .o_key_b(key_b), .o_auth_blk(auth_blk), .o_auth_uid(auth_uid),
    .i_chal_vld(chal_vld), .i_chal(chal), .o_tok_req(tok_req),
    .o_rdr_tok(rdr_tok), .i_tok_done(tok_done), .i_tok_ok(tok_ok),
    .i_card_tok(card_tok), .o_authed(authed), .o_mod_strong(mod_strong),
    .o_mod_cfg(mod_cfg));
  cc_link_monitor u_cc_link_monitor (
    .clk(lnk.clk), .i_rst_n(card_rst_n), .field_on(lnk.field_on),
    .sel(lnk.sel), .r2c_vld(lnk.r2c_vld), .r2c_dat(lnk.r2c_dat),
    .r2c_end(lnk.r2c_end), .c2r_vld(lnk.c2r_vld), .c2r_dat(lnk.c2r_dat),
    .c2r_end(lnk.c2r_end), .c2r_nib(lnk.c2r_nib));

  // Block contents differ from the status byte values on purpose
  assign mem_data = {16{mem_addr ^ 8'h3c}};

  always #50 i_clk = ~i_clk;

  function automatic logic [31:0] xs();
    rs = rs ^ (rs << 13);
    rs = rs ^ (rs >> 17);
    rs = rs ^ (rs << 5);
    return rs;
  endfunction

  function automatic logic [127:0] blk(input logic [7:0] b);
    blk = {16{b ^ 8'h3c}};
    if (b == 8'h00) blk[63:56] = cfg_exp ? 8'h20 : 8'h00;
  endfunction

  // Length 0 marks an expected timeout, 1 a nibble reply
  function automatic cc_exp_t ex(input logic [4:0] l, input logic [127:0] d);
    ex = '{to: l == 5'h00, nib: l == 5'h01, len: l, dat: d};
  endfunction

  task automatic chk(input logic [143:0] got, input logic [143:0] exp);
    n_compared++;
    if (got !== exp) begin
      errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("compared %0d mismatches %0d", n_compared, errors);
    if (errors == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // ****************************************
  // Reader side driver
  // ****************************************
  task automatic xfer(input logic [3:0] l, input logic [63:0] d,
                      input logic c, input cc_exp_t e);
    int k;
    k = 0;
    exp_q.push_back(e);
    req_len <= l;
    req_data <= d;
    req_crc <= c;
    req_vld <= 1'b1;
    @(negedge i_clk);
    req_vld <= 1'b0;
    do @(negedge i_clk); while (rdy !== 1'b1 && ++k < 3000);
  endtask

  task automatic mc(input logic [7:0] t, input logic ok);
    xfer(4'h2, {8'h43, t, 48'h0}, 1'b1, ex(5'h01, ok ? 128'ha : 128'h0));
  endtask

  task automatic rd(input logic [7:0] b, input logic ok);
    xfer(4'h2, {8'h30, b, 48'h0}, 1'b1, ok ? ex(5'h12, blk(b)) : ex(5'h01, 0));
  endtask

  task automatic auth(input logic kb, input logic [7:0] b, input logic ok);
    exp_key = kb;
    exp_blk = b;
    chal = xs();
    card_tok = xs();
    exp_tok = {xs(), xs()};
    tok_ok = ok;
    xfer(4'h2, {kb ? 8'h61 : 8'h60, b, 48'h0}, 1'b1, ex(5'h04, 128'(chal)));
    xfer(4'h8, exp_tok, 1'b0, ok ? ex(5'h04, 128'(card_tok)) : ex(5'h01, 0));
    chk(144'(authed), 144'(ok));
  endtask

  // Card user side: crypto stand-in answers one link cycle later
  always @(negedge lnk.clk) begin
    chal_vld <= 1'b0;
    tok_done <= 1'b0;
    if (chal_req === 1'b1) begin
      chal_vld <= 1'b1;
      chk(144'({key_b, auth_blk, auth_uid}),
          144'({exp_key, exp_blk, uid}));
    end
    if (tok_req === 1'b1) begin
      tok_done <= 1'b1;
      chk(144'(rdr_tok), 144'(exp_tok));
    end
  end

  always @(negedge i_clk) begin
    if (rsp_vld === 1'b1 || tmo === 1'b1) begin
      eo = exp_q.pop_front();
      go = eo.len == 5'h12 ? rsp_data[143:16] : eo.len == 5'h04 ?
           128'(rsp_data[31:0]) : 128'(rsp_data[3:0]);
      if (eo.to)
        chk(144'(tmo), 144'(1'b1));
      else
        chk(144'({tmo, rsp_nib, rsp_len, go}),
            144'(eo));
    end
  end

  always @(posedge i_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      test_done();
    end
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial begin
    {i_clk, rst_n, card_rst_n, req_vld, req_crc, shortcut, tok_ok} = '0;
    {chal_vld, tok_done, exp_key, req_len, req_data, exp_blk, exp_tok} = '0;
    {chal, card_tok, uid} = '0;
    {field_on, sel, cfg_exp} = 3'b111;
    rs = 32'h1;
    repeat (16) @(negedge i_clk);
    rst_n = 1'b1;
    repeat (6) @(negedge i_clk);
    card_rst_n = 1'b1;
    uid = xs();
    repeat (4) @(negedge i_clk);
    chk(144'({mod_strong, mod_cfg, authed}), 144'(3'b110));
    rd(8'h00, 1'b0);
    shortcut = 1'b1;
    rd(8'h00, 1'b1);
    shortcut = 1'b0;
    mc(8'h01, 1'b0);
    auth(1'b0, 8'h04, 1'b1);
    mc(8'h00, 1'b0);
    a = xs();
    rd(a[7:0], 1'b1);
    rd(8'hff, 1'b1);
    auth(1'b1, 8'h00, 1'b1);
    mc(8'h00, 1'b0);
    auth(1'b0, 8'h03, 1'b1);
    mc(8'h00, 1'b1);
    cfg_exp = 1'b0;
    chk(144'({mod_strong, mod_cfg}), 144'(2'b10));
    mc(8'h02, 1'b0);
    xfer(4'h4, {16'h4301, 16'hbeef, 32'h0}, 1'b0, ex(5'h01, 0));
    rd(8'h00, 1'b1);
    mc(8'h01, 1'b1);
    chk(144'(mod_cfg), 144'(1'b1));
    mc(8'h00, 1'b1);
    auth(1'b0, 8'h00, 1'b0);
    mc(8'h01, 1'b0);
    chk(144'(mod_cfg), 144'(1'b0));
    sel = 1'b0;
    repeat (8) @(negedge i_clk);
    sel = 1'b1;
    repeat (8) @(negedge i_clk);
    chk(144'(mod_strong), 144'(1'b0));
    auth(1'b0, 8'h00, 1'b1);
    mc(8'h01, 1'b1);
    chk(144'(mod_strong), 144'(1'b0));
    field_on = 1'b0;
    repeat (8) @(negedge i_clk);
    field_on = 1'b1;
    repeat (8) @(negedge i_clk);
    chk(144'(mod_strong), 144'(1'b1));
    // Silent card: reader must give up on its own
    card_rst_n = 1'b0;
    xfer(4'h2, {8'h30, 56'h0}, 1'b1, ex(5'h00, 0));
    test_done();
  end
endmodule
